// ---- rtl/rtccs_top.sv ----
// Control and status registers of the real-time clock, with periodic and alarm interrupt
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Alarm enable bits gate week and day alarms
// - Hour format bit picks 12 or 24 hour
// - Clock output runs unless both disables set
// - Codes 000-011 give off, low, 2Hz, 1Hz
// - Level codes fire per second, minute, hour, month
// - Seconds advance 92 us after pulse fall
// - Seconds write clears divider, pulls pin low in 2Hz and 1Hz modes
// - Level interrupt falls with seconds increment
// - Adjustment stretches or shrinks low phase
// - Threshold bit selects 1.6 V or 1.3 V
// - Low supply result sticks, zero write restarts
// - Oscillator good cleared on halt, stays cleared
// - Power-on flag set at power-up, held
// - Power-on flag holds other bits at zero, except oscillator good
// - Power-on flag cleared only by zero write
// - Power-up values zero except power-on flag
// - Periodic flag set when pin pulled low
// - Alarm flag sets 31 us after match
module rtccs_top #(
  parameter int SEC_DELAY_CYC = rtccs_pkg::SEC_DELAY_CYC,
  parameter int DIV_WIDTH = rtccs_pkg::DIV_WIDTH,
  parameter logic [31:0] ACC_INC = rtccs_pkg::ACC_INC
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic SCLK,
  input wire logic SI,
  output wire logic SO,
  output wire logic SO_OE,
  input wire logic OSC_HALT,
  input wire logic SUPPLY_LOW_16,
  input wire logic SUPPLY_LOW_13,
  input wire logic CARRY_MINUTE,
  input wire logic CARRY_HOUR,
  input wire logic CARRY_MONTH,
  input wire logic WEEK_ALARM_MATCH,
  input wire logic DAY_ALARM_MATCH,
  input wire logic ADJ_LENGTHEN,
  input wire logic ADJ_SHORTEN,
  output logic IRQ_N,
  output logic CLOCK_OUT_PIN,
  output logic SECOND_INC,
  output logic HOUR_24,
  output logic POWER_ON_FLAG
);
  localparam int SEC_CNT_W = $clog2(SEC_DELAY_CYC + 1);
  localparam int ALM_W = $clog2(rtccs_pkg::ALARM_DELAY_CYC + 1);
  localparam logic [SEC_CNT_W-1:0] SEC_LAST = SEC_CNT_W'(SEC_DELAY_CYC - 1);
  localparam logic [ALM_W-1:0] ALM_LAST = ALM_W'(rtccs_pkg::ALARM_DELAY_CYC - 1);
  localparam logic [DIV_WIDTH-1:0] ADJ_STEP = DIV_WIDTH'(rtccs_pkg::ADJ_STEP_TICKS);

  typedef struct packed {
    logic ce_s1;
    logic ce_s2;
    logic req_s1;
    logic req_s2;
    logic req_d;
    logic halt_s1;
    logic halt_s2;
    logic lo16_s1;
    logic lo16_s2;
    logic lo13_s1;
    logic lo13_s2;
    logic [31:0] acc;
    logic [DIV_WIDTH-1:0] div;
    logic sec_busy;
    logic [SEC_CNT_W-1:0] sec_cnt;
    logic sec_inc;
    logic [7:0] ctrl1;
    logic thresh;
    logic low_sup;
    logic osc_good;
    logic power_on_flag;
    logic clkdis_a;
    logic pflag;
    logic [1:0] alm_flag;
    logic [1:0] alm_busy;
    logic [1:0] match_d;
    logic [1:0][ALM_W-1:0] alm_cnt;
    logic [7:0] snap1;
    logic [7:0] snap2;
    logic irq_n;
    logic clk_out;
  } rtccs_core_t;

  rtccs_core_t r;
  rtccs_core_t n;
  logic tick;
  logic wr_hit;
  logic wr_c1;
  logic wr_c2;
  logic sec_start;
  logic per_event;
  logic [2:0] sel;
  logic [1:0] alm_en;
  logic [1:0] match_now;
  logic [7:0] wd;

  rtccs_link_if lnk ();

  rtccs_serial u_serial (
    .sclk(SCLK),
    .ce(CE),
    .si(SI),
    .so(SO),
    .so_oe(SO_OE),
    .lnk(lnk.link)
  );

  always_comb begin
    n = r;
    // Synchronisers for pins and the link write request
    n.ce_s1 = CE;
    n.ce_s2 = r.ce_s1;
    n.req_s1 = lnk.wr_req;
    n.req_s2 = r.req_s1;
    n.req_d = r.req_s2;
    n.halt_s1 = OSC_HALT;
    n.halt_s2 = r.halt_s1;
    n.lo16_s1 = SUPPLY_LOW_16;
    n.lo16_s2 = r.lo16_s1;
    n.lo13_s1 = SUPPLY_LOW_13;
    n.lo13_s2 = r.lo13_s1;
    n.sec_inc = 1'b0;
    wd = lnk.wr_data;
    wr_hit = r.req_s2 & ~r.req_d;
    wr_c1 = wr_hit && (lnk.wr_addr == rtccs_pkg::ADDR_CTRL1);
    wr_c2 = wr_hit && (lnk.wr_addr == rtccs_pkg::ADDR_CTRL2);
    sec_start = 1'b0;

    // Oscillator timebase and clock output
    n.acc = r.acc + ACC_INC;
    tick = n.acc[31] & ~r.acc[31];
    n.clk_out = (r.ctrl1[rtccs_pkg::C1_CLKDIS_B] & r.clkdis_a) | n.acc[31];

    // Sub-second divider
    if (wr_hit && (lnk.wr_addr == rtccs_pkg::ADDR_SECONDS)) begin
      n.div = '0;
      n.sec_busy = 1'b0;
    end else if (ADJ_SHORTEN && !r.div[DIV_WIDTH-1]) begin
      n.div = r.div + ADJ_STEP;
    end else if (ADJ_LENGTHEN && !r.div[DIV_WIDTH-1] && (r.div >= ADJ_STEP)) begin
      n.div = r.div - ADJ_STEP;
    end else if (tick) begin
      n.div = r.div + DIV_WIDTH'(1);
      sec_start = &r.div;
    end

    // Seconds increment follows the falling edge after a delay
    if (sec_start) begin
      n.sec_busy = 1'b1;
      n.sec_cnt = '0;
    end else if (r.sec_busy) begin
      if (r.sec_cnt == SEC_LAST) begin
        n.sec_busy = 1'b0;
        n.sec_inc = 1'b1;
      end else begin
        n.sec_cnt = r.sec_cnt + SEC_CNT_W'(1);
      end
    end

    // Register writes
    if (wr_c1) begin
      n.ctrl1 = wd;
    end
    if (wr_c2) begin
      n.thresh = wd[rtccs_pkg::C2_THRESH];
      n.clkdis_a = wd[rtccs_pkg::C2_CLKDIS_A];
      n.osc_good = wd[rtccs_pkg::C2_OSC_GOOD];
      if (!wd[rtccs_pkg::C2_LOW_SUP]) begin
        n.low_sup = 1'b0;
      end
      if (!wd[rtccs_pkg::C2_PON]) begin
        n.power_on_flag = 1'b0;
      end
      n.alm_flag = r.alm_flag & wd[rtccs_pkg::C2_WFLAG:rtccs_pkg::C2_DFLAG];
    end

    // Supply monitor stops once it has tripped
    if (!r.low_sup && (r.thresh ? r.lo13_s2 : r.lo16_s2)) begin
      n.low_sup = 1'b1;
    end

    // Halt sensing wins over a write of one
    if (r.halt_s2) begin
      n.osc_good = 1'b0;
    end

    // Alarm flags, set after a fixed delay from the match
    alm_en = r.ctrl1[rtccs_pkg::C1_WEEK_EN:rtccs_pkg::C1_DAY_EN];
    match_now = {WEEK_ALARM_MATCH, DAY_ALARM_MATCH};
    n.match_d = match_now;
    for (int i = 0; i < 2; i++) begin
      if (!alm_en[i]) begin
        n.alm_flag[i] = 1'b0;
        n.alm_busy[i] = 1'b0;
      end else if (match_now[i] && !r.match_d[i]) begin
        n.alm_busy[i] = 1'b1;
        n.alm_cnt[i] = '0;
      end else if (r.alm_busy[i]) begin
        if (r.alm_cnt[i] == ALM_LAST) begin
          n.alm_busy[i] = 1'b0;
          n.alm_flag[i] = 1'b1;
        end else begin
          n.alm_cnt[i] = r.alm_cnt[i] + ALM_W'(1);
        end
      end
    end

    // Periodic interrupt source
    sel = r.ctrl1[rtccs_pkg::C1_SEL_LSB +: 3];
    case (sel)
      rtccs_pkg::SEL_SEC: per_event = n.sec_inc;
      rtccs_pkg::SEL_MIN: per_event = n.sec_inc & CARRY_MINUTE;
      rtccs_pkg::SEL_HOUR: per_event = n.sec_inc & CARRY_HOUR;
      rtccs_pkg::SEL_MONTH: per_event = n.sec_inc & CARRY_MONTH;
      default: per_event = 1'b0;
    endcase
    if (sel[rtccs_pkg::SEL_LEVEL_BIT]) begin
      if (per_event) begin
        n.pflag = 1'b1;
      end else if (wr_c2 && !wd[rtccs_pkg::C2_PFLAG]) begin
        n.pflag = 1'b0;
      end
    end else begin
      case (sel)
        rtccs_pkg::SEL_LOW: n.pflag = 1'b1;
        rtccs_pkg::SEL_2HZ: n.pflag = ~n.div[DIV_WIDTH-2];
        rtccs_pkg::SEL_1HZ: n.pflag = ~n.div[DIV_WIDTH-1];
        default: n.pflag = 1'b0;
      endcase
    end

    // Power-on flag holds everything else cleared, except oscillator good
    if (r.power_on_flag) begin
      n.ctrl1 = rtccs_pkg::CTRL1_RESET;
      n.thresh = 1'b0;
      n.low_sup = 1'b0;
      n.clkdis_a = 1'b0;
      n.pflag = 1'b0;
      n.alm_flag = 2'h0;
      n.alm_busy = 2'h0;
    end

    n.irq_n = ~(n.pflag | (|n.alm_flag));

    // Snapshot for reads, frozen while a frame is open
    if (!r.ce_s2) begin
      n.snap1 = n.ctrl1;
      n.snap2 = {n.thresh, n.low_sup, n.osc_good, n.power_on_flag, n.clkdis_a, n.pflag, n.alm_flag};
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      r <= '0;
      r.ctrl1 <= rtccs_pkg::CTRL1_RESET;
      r.power_on_flag <= rtccs_pkg::CTRL2_RESET[rtccs_pkg::C2_PON];
      r.snap1 <= rtccs_pkg::CTRL1_RESET;
      r.snap2 <= rtccs_pkg::CTRL2_RESET;
      r.irq_n <= 1'b1;
      r.clk_out <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign lnk.snap_ctrl1 = r.snap1;
  assign lnk.snap_ctrl2 = r.snap2;
  assign IRQ_N = r.irq_n;
  assign CLOCK_OUT_PIN = r.clk_out;
  assign SECOND_INC = r.sec_inc;
  assign HOUR_24 = r.ctrl1[rtccs_pkg::C1_HOUR24];
  assign POWER_ON_FLAG = r.power_on_flag;
endmodule : rtccs_top
`default_nettype wire

// ---- pkg/rtccs_pkg.sv ----
// Package with addresses, field positions, reset values and timing counts
`default_nettype none
package rtccs_pkg;
  // Register addresses on the serial link
  localparam logic [3:0] ADDR_SECONDS = 4'h0;
  localparam logic [3:0] ADDR_CTRL1 = 4'he;
  localparam logic [3:0] ADDR_CTRL2 = 4'hf;
  // Control one fields
  localparam int C1_WEEK_EN = 7;
  localparam int C1_DAY_EN = 6;
  localparam int C1_HOUR24 = 5;
  localparam int C1_CLKDIS_B = 4;
  localparam int C1_TEST = 3;
  localparam int C1_SEL_LSB = 0;
  // Control two fields
  localparam int C2_THRESH = 7;
  localparam int C2_LOW_SUP = 6;
  localparam int C2_OSC_GOOD = 5;
  localparam int C2_PON = 4;
  localparam int C2_CLKDIS_A = 3;
  localparam int C2_PFLAG = 2;
  localparam int C2_WFLAG = 1;
  localparam int C2_DFLAG = 0;
  // Values after power-on
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h10;
  // Periodic select codes
  localparam logic [2:0] SEL_OFF = 3'h0;
  localparam logic [2:0] SEL_LOW = 3'h1;
  localparam logic [2:0] SEL_2HZ = 3'h2;
  localparam logic [2:0] SEL_1HZ = 3'h3;
  localparam logic [2:0] SEL_SEC = 3'h4;
  localparam logic [2:0] SEL_MIN = 3'h5;
  localparam logic [2:0] SEL_HOUR = 3'h6;
  localparam logic [2:0] SEL_MONTH = 3'h7;
  localparam int SEL_LEVEL_BIT = 2;
  // Clocking
  localparam longint REF_CLK_HZ = 50000000;
  localparam longint REF_CLK_PERIOD_NS = 20;
  localparam longint OSC_HZ = 32768;
  localparam int ACC_WIDTH = 32;
  localparam logic [31:0] ACC_INC = 32'((OSC_HZ << ACC_WIDTH) / REF_CLK_HZ);
  localparam int DIV_WIDTH = 15;
  // Alarm flag delay after a match, least time
  localparam longint ALARM_DELAY_NS = 31000;
  localparam int ALARM_DELAY_CYC = int'((ALARM_DELAY_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS);
  // Seconds increment delay after the falling edge, least time
  localparam longint SEC_DELAY_NS = 92000;
  localparam int SEC_DELAY_CYC = int'((SEC_DELAY_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS);
  // Adjustment step in oscillator ticks, longest time
  localparam longint ADJ_STEP_NS = 3784000;
  localparam int ADJ_STEP_TICKS = int'((ADJ_STEP_NS * OSC_HZ) / 1000000000);
endpackage : rtccs_pkg
`default_nettype wire

// ---- pkg/rtccs_link_if.sv ----
// Interface between the serial link end and the register core
`timescale 1ns/1ns
`default_nettype none
interface rtccs_link_if;
  logic wr_req;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] snap_ctrl1;
  logic [7:0] snap_ctrl2;
  modport link (output wr_req, output wr_addr, output wr_data, input snap_ctrl1, input snap_ctrl2);
  modport core (input wr_req, input wr_addr, input wr_data, output snap_ctrl1, output snap_ctrl2);
endinterface : rtccs_link_if
`default_nettype wire

// ---- rtl/rtccs_serial.sv ----
// Serial link end, clocked by the link clock
`timescale 1ns/1ns
`default_nettype none
module rtccs_serial (
  input wire logic sclk,
  input wire logic ce,
  input wire logic si,
  output logic so,
  output logic so_oe,
  rtccs_link_if.link lnk
);
  typedef enum logic [1:0] {PH_ADDR = 2'b01, PH_DATA = 2'b10} rtccs_phase_t;
  typedef struct packed {
    rtccs_phase_t phase;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic [3:0] addr;
    logic rd;
    logic wr_req;
    logic [7:0] wr_data;
    logic so;
    logic so_oe;
  } rtccs_ser_t;

  rtccs_ser_t r;
  rtccs_ser_t n;
  logic [7:0] full;
  logic [7:0] rd_byte;

  always_comb begin
    n = r;
    full = {r.shift[6:0], si};
    n.bit_cnt = r.bit_cnt + 3'h1;
    n.shift = full;
    case (full[7:4])
      rtccs_pkg::ADDR_CTRL1: rd_byte = lnk.snap_ctrl1;
      rtccs_pkg::ADDR_CTRL2: rd_byte = lnk.snap_ctrl2;
      default: rd_byte = 8'h00;
    endcase
    case (r.phase)
      PH_ADDR: begin
        if (r.bit_cnt == 3'h7) begin
          n.phase = PH_DATA;
          n.addr = full[7:4];
          n.rd = full[3];
          if (full[3]) begin
            n.shift = rd_byte;
            n.so = rd_byte[7];
            n.so_oe = 1'b1;
          end
        end
      end
      PH_DATA: begin
        if (r.rd) begin
          n.shift = {r.shift[6:0], 1'b0};
          n.so = r.shift[6];
        end
        if (r.bit_cnt == 3'h7) begin
          n.phase = PH_ADDR;
          n.so_oe = 1'b0;
          if (!r.rd) begin
            n.wr_data = full;
            n.wr_req = 1'b1;
          end
        end
      end
      default: n.phase = PH_ADDR;
    endcase
  end

  // Frame ends with chip enable low
  always_ff @(posedge sclk or negedge ce) begin
    if (!ce) begin
      r <= '0;
      r.phase <= PH_ADDR;
    end else begin
      r <= n;
    end
  end

  assign so = r.so;
  assign so_oe = r.so_oe;
  assign lnk.wr_req = r.wr_req;
  assign lnk.wr_addr = r.addr;
  assign lnk.wr_data = r.wr_data;
endmodule : rtccs_serial
`default_nettype wire

// ---- testbench/rtccs_host.sv ----
// Host model on the four-wire serial link
`timescale 1ns/1ns
`default_nettype none
module rtccs_host (
  output logic CE,
  output logic SCLK,
  output logic SI,
  input wire logic SO,
  input wire logic SO_OE
);
  // Drive enable matched the frame type in the last frame
  logic oe_ok;
  initial begin
    CE = 1'b0;
    SCLK = 1'b0;
    SI = 1'b0;
    oe_ok = 1'b1;
  end
  // One frame, MSB first; link clock only inside it
  task automatic xfer(input logic [3:0] a, input logic rd, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {a, rd, 3'h0, d & ((a == rtccs_pkg::ADDR_CTRL1) ? 8'hf7 : 8'hff)};
    q = 8'h00;
    oe_ok = 1'b1;
    CE = 1'b1;
    #100;
    for (int i = 15; i >= 0; i--) begin
      SI = f[i];
      #62;
      if (i < 8) q[i] = SO;
      if (i < 8 && SO_OE !== rd) oe_ok = 1'b0;
      SCLK = 1'b1;
      #63;
      SCLK = 1'b0;
    end
    #100;
    CE = 1'b0;
    SI = ~SI;
    #200;
    if (SO_OE !== 1'b0) oe_ok = 1'b0;
  endtask : xfer
endmodule : rtccs_host
`default_nettype wire

// ---- testbench/rtccs_sva.sv ----
// Checker for the control and status register block
`timescale 1ns/1ns
`default_nettype none
module rtccs_sva (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic WEEK_ALARM_MATCH,
  input wire logic IRQ_N,
  input wire logic CLOCK_OUT_PIN,
  input wire logic SECOND_INC,
  input wire logic HOUR_24,
  input wire logic POWER_ON_FLAG
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  sequence quiet_link;
    !CE [*8];
  endsequence
  a_pon_irq_idle: assert property (POWER_ON_FLAG |-> IRQ_N) else $error("irq active under power-on flag");
  a_pon_hour_zero: assert property (POWER_ON_FLAG |-> !HOUR_24) else $error("hour mode set under flag");
  a_pon_no_set: assert property (!POWER_ON_FLAG |=> !POWER_ON_FLAG) else $error("power-on flag set again");
  a_pon_by_write: assert property (quiet_link |=> $stable(POWER_ON_FLAG)) else $error("flag moved idle");
  a_hour_by_write: assert property (quiet_link |=> $stable(HOUR_24)) else $error("hour mode moved idle");
  a_clkout_runs: assert property (POWER_ON_FLAG |-> ##[1:1000] $changed(CLOCK_OUT_PIN))
    else $error("clock output stuck");
  a_sec_spaced: assert property (SECOND_INC |=> !SECOND_INC [*8]) else $error("seconds pulse too close");
  a_alarm_gated: assert property (POWER_ON_FLAG && $rose(WEEK_ALARM_MATCH) |-> IRQ_N [*8])
    else $error("alarm fired while disabled");
endmodule : rtccs_sva
bind rtccs_top rtccs_sva u_sva (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CE(CE), .WEEK_ALARM_MATCH(WEEK_ALARM_MATCH),
  .IRQ_N(IRQ_N), .CLOCK_OUT_PIN(CLOCK_OUT_PIN), .SECOND_INC(SECOND_INC), .HOUR_24(HOUR_24),
  .POWER_ON_FLAG(POWER_ON_FLAG));
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the control and status register block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int SEC_DLY = 4;
  // Divider ticks in half a second at divider width 8, and one adjustment step
  localparam int HALF_TICKS = 128;
  localparam int ADJ = rtccs_pkg::ADJ_STEP_TICKS;
  typedef struct packed {logic [3:0] a; logic [7:0] d; logic hour; logic run;} rtccs_row_t;
  rtccs_row_t rows [5] = '{'{4'hf, 8'h00, 1'b0, 1'b1}, '{4'he, 8'h20, 1'b1, 1'b1}, '{4'he, 8'h10, 1'b0, 1'b1},
    '{4'hf, 8'h08, 1'b0, 1'b0}, '{4'hf, 8'h80, 1'b0, 1'b1}};
  logic ref_clk, sys_rst, halt, low16, low13, c_min, c_hour, c_mon, wk, dy, adj_l, adj_s, r;
  wire logic ce, sclk, si, so, so_oe, irq_n, clk_out, sec_inc, hour_24, power_on_flag;
  int n_fail = 0;
  int checks_done = 0;
  int n;
  logic [7:0] q;
  rtccs_host host (.CE(ce), .SCLK(sclk), .SI(si), .SO(so), .SO_OE(so_oe));
  rtccs_top #(.SEC_DELAY_CYC(SEC_DLY), .DIV_WIDTH(8), .ACC_INC(32'h40000000)) dut (.REF_CLK(ref_clk),
    .SYS_RST(sys_rst), .CE(ce), .SCLK(sclk), .SI(si), .SO(so), .SO_OE(so_oe), .OSC_HALT(halt),
    .SUPPLY_LOW_16(low16),
    .SUPPLY_LOW_13(low13), .CARRY_MINUTE(c_min), .CARRY_HOUR(c_hour), .CARRY_MONTH(c_mon),
    .WEEK_ALARM_MATCH(wk), .DAY_ALARM_MATCH(dy), .ADJ_LENGTHEN(adj_l), .ADJ_SHORTEN(adj_s), .IRQ_N(irq_n),
    .CLOCK_OUT_PIN(clk_out), .SECOND_INC(sec_inc), .HOUR_24(hour_24), .POWER_ON_FLAG(power_on_flag));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host.xfer(a, 1'b0, d, q);
    cyc(2);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    host.xfer(a, 1'b1, 8'h00, q);
  endtask : rd
  task automatic wait_sec;
    for (int i = 0; i < 3000 && sec_inc !== 1'b1; i++) cyc(1);
    check(8'(sec_inc), 8'h01);
  endtask : wait_sec
  task automatic wait_irq(input logic v);
    for (int i = 0; i < 3000 && irq_n !== v; i++) cyc(1);
    check(8'(irq_n), 8'(v));
  endtask : wait_irq
  initial begin
    #1200000;
    n_fail++;
    stop_test;
  end
  initial begin
    {halt, low16, low13, c_min, c_hour, c_mon, wk, dy, adj_l, adj_s} = 10'h000;
    sys_rst = 1'b1;
    cyc(4);
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      check(q, rows[i].d);
      check(8'(host.oe_ok), 8'h01);
      check(8'(hour_24), 8'(rows[i].hour));
      n = 0;
      for (int k = 0; k < 24; k++) begin
        r = clk_out;
        cyc(1);
        n += int'(clk_out !== r);
      end
      check(8'(n > 0), 8'(rows[i].run));
    end
    check(8'(power_on_flag), 8'h00);
    low16 = 1'b1;
    wr(4'hf, 8'h00);
    rd(4'hf);
    check(q, 8'h40);
    low16 = 1'b0;
    wr(4'hf, 8'h00);
    rd(4'hf);
    check(q, 8'h00);
    wr(4'hf, 8'h80);
    low16 = 1'b1;
    cyc(8);
    rd(4'hf);
    check(q, 8'h80);
    low16 = 1'b0;
    wr(4'hf, 8'h20);
    rd(4'hf);
    check(q, 8'h20);
    halt = 1'b1;
    cyc(4);
    halt = 1'b0;
    cyc(6);
    rd(4'hf);
    check(q, 8'h00);
    for (int c = 0; c < 2; c++) begin
      wr(4'he, 8'(c));
      check(8'(irq_n), 8'(c == 0));
    end
    for (int c = 4; c < 8; c++) begin
      {c_mon, c_hour, c_min} = 3'h7 ^ ((c > 4) ? 3'(1 << (c - 5)) : 3'h0);
      wr(4'he, 8'(c));
      wr(4'hf, 8'h00);
      wait_sec;
      cyc(3);
      check(8'(irq_n), 8'(c != 4));
      {c_mon, c_hour, c_min} = 3'h7;
      wait_sec;
      cyc(3);
      check(8'(irq_n), 8'h00);
      rd(4'hf);
      check(q, 8'h04);
      wr(4'hf, 8'h00);
      check(8'(irq_n), 8'h01);
    end
    for (int c = 2; c < 4; c++) begin
      wr(4'he, 8'(c));
      wait_irq(1'b1);
      wait_irq(1'b0);
      for (n = 0; n < 2000 && irq_n === 1'b0; n++) cyc(1);
      check(8'(n > 256 * (c - 1) - 3 && n < 256 * (c - 1) + 3), 8'h01);
    end
    wait_irq(1'b0);
    for (n = 0; n < 2000 && sec_inc !== 1'b1; n++) cyc(1);
    check(8'(n > SEC_DLY - 3 && n < SEC_DLY + 3), 8'h01);
    wait_irq(1'b1);
    wait_irq(1'b0);
    adj_s = 1'b1;
    cyc(1);
    adj_s = 1'b0;
    for (n = 1; n < 2000 && irq_n === 1'b0; n++) cyc(1);
    check(8'(n > 4 * (HALF_TICKS - ADJ) - 3 && n < 4 * (HALF_TICKS - ADJ) + 3), 8'h01);
    wait_irq(1'b0);
    cyc(4 * ADJ + 8);
    adj_l = 1'b1;
    cyc(1);
    adj_l = 1'b0;
    for (n = 4 * ADJ + 9; n < 4000 && irq_n === 1'b0; n++) cyc(1);
    check(8'(n > 4 * (HALF_TICKS + ADJ) - 3 && n < 4 * (HALF_TICKS + ADJ) + 3), 8'h01);
    wait_irq(1'b1);
    wr(4'h0, 8'h00);
    check(8'(irq_n), 8'h00);
    wr(4'he, 8'h80);
    wk = 1'b1;
    cyc(1540);
    check(8'(irq_n), 8'h01);
    cyc(20);
    check(8'(irq_n), 8'h00);
    wk = 1'b0;
    dy = 1'b1;
    cyc(1600);
    rd(4'hf);
    check(q, 8'h02);
    wr(4'hf, 8'h00);
    check(8'(irq_n), 8'h01);
    dy = 1'b0;
    sys_rst = 1'b1;
    cyc(4);
    sys_rst = 1'b0;
    cyc(1);
    check(8'({power_on_flag, irq_n}), 8'h03);
    rd(4'he);
    check(q, 8'h00);
    wr(4'he, 8'h20);
    wr(4'hf, 8'h10);
    wk = 1'b1;
    cyc(10);
    rd(4'he);
    check(q, 8'h00);
    rd(4'hf);
    check(q, 8'h10);
    stop_test;
  end
endmodule : testbench
`default_nettype wire
